/* core/fhm_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module fhm_monitor #(
  parameter longint unsigned HOUR_CYCLES = fhm_pkg::HOUR_CYCLES
) (
  input  wire logic                clk_i,          // System clock, 40 MHz
  input  wire logic                rst_i,          // Synchronous reset, active high
  input  wire logic [31:0]         wb_adr_i,       // Wishbone address
  input  wire logic [31:0]         wb_dat_i,       // Wishbone write data
  input  wire logic [3:0]          wb_sel_i,       // Wishbone byte selects
  input  wire logic                wb_we_i,        // Wishbone write enable
  input  wire logic                wb_cyc_i,       // Wishbone cycle
  input  wire logic                wb_stb_i,       // Wishbone strobe
  output logic [31:0]              wb_dat_o,       // Wishbone read data
  output logic                     wb_ack_o,       // Wishbone acknowledge
  output logic                     irq_o,          // Level interrupt
  input  wire logic                fault_i,        // New fault event pulse
  input  wire logic [7:0]          fault_code_i,   // Code of the new fault
  input  wire logic                fault_reset_i,  // Fault reset pulse
  input  wire logic                run_i,          // Run command active
  input  wire logic                loop_enable_i,  // Closed-loop control enabled
  input  wire logic                encoder_fb_i,   // Encoder speed feedback configured
  input  wire logic [15:0]         motor_rpm_i,    // Motor speed, 1 rpm
  input  wire fhm_pkg::fhm_drive_s drive_i,        // Live drive values
  input  wire fhm_pkg::fhm_analog_s analog_i,      // Live analog monitors
  output logic [15:0]              analog_out_a_o, // Analog output A, 1000 = 10 V
  output logic [15:0]              analog_out_b_o  // Analog output B, 1000 = 10 V
);

  function automatic logic [16:0] hour_step(input logic [16:0] v);
    hour_step = (v >= fhm_pkg::HOURS_MAX) ? 17'h00000 : v + 17'h00001;
  endfunction

  function automatic logic [15:0] scale_out(input logic [15:0] src, input logic [7:0] gain);
    logic [23:0] prod;
    logic [23:0] q;
    prod = src * gain;
    q    = prod / {16'h0000, fhm_pkg::GAIN_UNITY};
    scale_out = (q > {8'h00, fhm_pkg::FULL_SCALE}) ? fhm_pkg::FULL_SCALE : q[15:0];
  endfunction

  function automatic logic [15:0] pick_src(input logic [7:0] sel,
                                          input fhm_pkg::fhm_drive_s d,
                                          input fhm_pkg::fhm_analog_s a,
                                          input logic loop_on);
    pick_src = 16'h0000;
    if (sel == fhm_pkg::SRC_FREQ_CMD) begin
      pick_src = d.freq_cmd;
    end else if (sel == fhm_pkg::SRC_OUT_FREQ) begin
      pick_src = d.out_freq;
    end else if (sel == fhm_pkg::SRC_OUT_CURR) begin
      pick_src = d.out_current;
    end else if (sel == fhm_pkg::SRC_OUT_VOLT) begin
      pick_src = d.out_voltage;
    end else if (sel == fhm_pkg::SRC_VOLT_IN) begin
      pick_src = loop_on ? a.loop_feedback : a.voltage_input;
    end else if (sel == fhm_pkg::SRC_CURR_IN) begin
      pick_src = loop_on ? a.loop_feedback : a.current_input;
    end else if (sel == fhm_pkg::SRC_AUX_IN) begin
      pick_src = loop_on ? a.loop_target : a.aux_input;
    end else if (sel == fhm_pkg::SRC_SPD_FB) begin
      pick_src = a.speed_fb;
    end else if (sel == fhm_pkg::SRC_SPD_COMP) begin
      pick_src = a.speed_comp;
    end else if (sel == fhm_pkg::SRC_LOOP_IN) begin
      pick_src = a.loop_in;
    end else if (sel == fhm_pkg::SRC_LOOP_OUT) begin
      pick_src = a.loop_out;
    end
  endfunction

  // Hour prescaler and counters
  logic [47:0] presc;
  logic [47:0] next_presc;
  logic        hour_tick;
  logic        next_hour_tick;
  logic [16:0] hrs_between;
  logic [16:0] next_hrs_between;
  logic [16:0] pwr_hrs;
  logic [16:0] next_pwr_hrs;
  logic [16:0] run_hrs;
  logic [16:0] next_run_hrs;

  always_comb begin
    next_presc     = presc + 48'h000000000001;
    next_hour_tick = 1'b0;
    if (presc >= HOUR_CYCLES[47:0] - 48'h000000000001) begin
      next_presc     = 48'h000000000000;
      next_hour_tick = 1'b1;
    end
  end

  always_comb begin
    next_hrs_between = hrs_between;
    next_pwr_hrs     = pwr_hrs;
    next_run_hrs     = run_hrs;
    if (hour_tick && hrs_between < fhm_pkg::HOURS_MAX) begin
      next_hrs_between = hrs_between + 17'h00001;
    end
    if (fault_reset_i) begin
      next_hrs_between = 17'h00000;
    end
    if (hour_tick) begin
      next_pwr_hrs = hour_step(pwr_hrs);
    end
    if (hour_tick && run_i) begin
      next_run_hrs = hour_step(run_hrs);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc       <= 48'h000000000000;
      hour_tick   <= 1'b0;
      hrs_between <= 17'h00000;
      pwr_hrs     <= 17'h00000;
      run_hrs     <= 17'h00000;
    end else begin
      presc       <= next_presc;
      hour_tick   <= next_hour_tick;
      hrs_between <= next_hrs_between;
      pwr_hrs     <= next_pwr_hrs;
      run_hrs     <= next_run_hrs;
    end
  end

  // Fault history and capture
  logic [7:0]          slot [4];
  logic [7:0]          next_slot [4];
  fhm_pkg::fhm_drive_s cap;
  fhm_pkg::fhm_drive_s next_cap;
  logic                loop_mon_clr;
  logic                next_loop_mon_clr;

  always_comb begin
    next_slot         = slot;
    next_cap          = cap;
    next_loop_mon_clr = loop_mon_clr;
    if (fault_reset_i) begin
      for (int i = 0; i < 4; i++) begin
        next_slot[i] = 8'h00;
      end
      next_cap          = '0;
      next_loop_mon_clr = 1'b1;
    end else if (fault_i) begin
      next_slot[3] = slot[2];
      next_slot[2] = slot[1];
      next_slot[1] = slot[0];
      next_slot[0] = fault_code_i;
      next_cap          = drive_i;
      next_loop_mon_clr = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 4; i++) begin
        slot[i] <= 8'h00;
      end
      cap          <= '0;
      loop_mon_clr <= 1'b0;
    end else begin
      slot         <= next_slot;
      cap          <= next_cap;
      loop_mon_clr <= next_loop_mon_clr;
    end
  end

  // Configuration, interrupts and bus
  logic [7:0]  ao_a_src;
  logic [7:0]  next_ao_a_src;
  logic [7:0]  ao_b_src;
  logic [7:0]  next_ao_b_src;
  logic [7:0]  ao_a_gain;
  logic [7:0]  next_ao_a_gain;
  logic [7:0]  ao_b_gain;
  logic [7:0]  next_ao_b_gain;
  logic [2:0]  irq_stat;
  logic [2:0]  next_irq_stat;
  logic [2:0]  irq_mask;
  logic [2:0]  next_irq_mask;
  logic [31:0] next_dat;
  logic        next_ack;
  logic        next_irq;
  logic [15:0] next_ao_a;
  logic [15:0] next_ao_b;
  logic        wr;
  logic [7:0]  adr;
  logic [31:0] rd;
  logic [15:0] lm_in;
  logic [15:0] lm_out;

  assign wr     = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign adr    = wb_adr_i[7:0];
  assign lm_in  = loop_mon_clr ? 16'h0000 : analog_i.loop_in;
  assign lm_out = loop_mon_clr ? 16'h0000 : analog_i.loop_out;

  always_comb begin
    rd = 32'h00000000;
    if (adr == fhm_pkg::REG_FAULT_CUR) begin
      rd = {24'h000000, slot[0]};
    end else if (adr == fhm_pkg::REG_FAULT_PREV) begin
      rd = {24'h000000, slot[1]};
    end else if (adr == fhm_pkg::REG_FAULT_TWO) begin
      rd = {24'h000000, slot[2]};
    end else if (adr == fhm_pkg::REG_FAULT_THREE) begin
      rd = {24'h000000, slot[3]};
    end else if (adr == fhm_pkg::REG_HRS_BETWEEN) begin
      rd = {15'h0000, hrs_between};
    end else if (adr == fhm_pkg::REG_CAP_FCMD) begin
      rd = {16'h0000, cap.freq_cmd};
    end else if (adr == fhm_pkg::REG_CAP_FOUT) begin
      rd = {16'h0000, cap.out_freq};
    end else if (adr == fhm_pkg::REG_CAP_CURR) begin
      rd = {16'h0000, cap.out_current};
    end else if (adr == fhm_pkg::REG_CAP_VOLT) begin
      rd = {16'h0000, cap.out_voltage};
    end else if (adr == fhm_pkg::REG_CAP_BUS) begin
      rd = {16'h0000, cap.bus_voltage};
    end else if (adr == fhm_pkg::REG_CAP_PINS) begin
      rd = {16'h0000, cap.out_pins, cap.in_pins};
    end else if (adr == fhm_pkg::REG_PWR_HRS) begin
      rd = {15'h0000, pwr_hrs};
    end else if (adr == fhm_pkg::REG_RUN_HRS) begin
      rd = {15'h0000, run_hrs};
    end else if (adr == fhm_pkg::REG_FW_VER) begin
      rd = {16'h0000, fhm_pkg::FW_VERSION};
    end else if (adr == fhm_pkg::REG_MOTOR_SPEED) begin
      rd = {16'h0000, encoder_fb_i ? motor_rpm_i : 16'h0000};
    end else if (adr == fhm_pkg::REG_AO_CTRL) begin
      rd = {ao_b_gain, ao_a_gain, ao_b_src, ao_a_src};
    end else if (adr == fhm_pkg::REG_AO_VALUES) begin
      rd = {analog_out_b_o, analog_out_a_o};
    end else if (adr == fhm_pkg::REG_LOOP_MON) begin
      rd = {lm_out, lm_in};
    end else if (adr == fhm_pkg::REG_IRQ_STATUS) begin
      rd = {29'h00000000, irq_stat};
    end else if (adr == fhm_pkg::REG_IRQ_MASK) begin
      rd = {29'h00000000, irq_mask};
    end else if (adr == fhm_pkg::REG_LIVE_PINS) begin
      rd = {16'h0000, drive_i.out_pins, drive_i.in_pins};
    end
  end

  always_comb begin
    next_ao_a_src  = ao_a_src;
    next_ao_b_src  = ao_b_src;
    next_ao_a_gain = ao_a_gain;
    next_ao_b_gain = ao_b_gain;
    next_irq_mask  = irq_mask;
    next_irq_stat  = irq_stat;
    if (wr && adr == fhm_pkg::REG_AO_CTRL) begin
      if (wb_sel_i[0]) next_ao_a_src = wb_dat_i[fhm_pkg::AO_A_SRC_POS +: 8];
      if (wb_sel_i[1]) next_ao_b_src = wb_dat_i[fhm_pkg::AO_B_SRC_POS +: 8];
      if (wb_sel_i[2]) next_ao_a_gain = wb_dat_i[fhm_pkg::AO_A_GAIN_POS +: 8];
      if (wb_sel_i[3]) next_ao_b_gain = wb_dat_i[fhm_pkg::AO_B_GAIN_POS +: 8];
    end
    if (wr && adr == fhm_pkg::REG_IRQ_MASK && wb_sel_i[0]) begin
      next_irq_mask = wb_dat_i[2:0];
    end
    if (wr && adr == fhm_pkg::REG_IRQ_STATUS && wb_sel_i[0]) begin
      next_irq_stat = irq_stat & ~wb_dat_i[2:0];
    end
    // Events set after the clear so a same-cycle event survives
    if (fault_i) next_irq_stat[fhm_pkg::IRQ_FAULT_BIT] = 1'b1;
    if (fault_reset_i) next_irq_stat[fhm_pkg::IRQ_CLEAR_BIT] = 1'b1;
    if (hour_tick) next_irq_stat[fhm_pkg::IRQ_HOUR_BIT] = 1'b1;
    next_irq = |(next_irq_stat & next_irq_mask);
    next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
    next_dat = next_ack ? rd : 32'h00000000;
    next_ao_a = scale_out(pick_src(ao_a_src, drive_i, analog_i, loop_enable_i), ao_a_gain);
    next_ao_b = scale_out(pick_src(ao_b_src, drive_i, analog_i, loop_enable_i), ao_b_gain);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ao_a_src       <= fhm_pkg::AO_SRC_RESET;
      ao_b_src       <= fhm_pkg::AO_SRC_RESET;
      ao_a_gain      <= fhm_pkg::AO_GAIN_RESET;
      ao_b_gain      <= fhm_pkg::AO_GAIN_RESET;
      irq_stat       <= 3'h0;
      irq_mask       <= fhm_pkg::IRQ_MASK_RESET;
      irq_o          <= 1'b0;
      wb_ack_o       <= 1'b0;
      wb_dat_o       <= 32'h00000000;
      analog_out_a_o <= 16'h0000;
      analog_out_b_o <= 16'h0000;
    end else begin
      ao_a_src       <= next_ao_a_src;
      ao_b_src       <= next_ao_b_src;
      ao_a_gain      <= next_ao_a_gain;
      ao_b_gain      <= next_ao_b_gain;
      irq_stat       <= next_irq_stat;
      irq_mask       <= next_irq_mask;
      irq_o          <= next_irq;
      wb_ack_o       <= next_ack;
      wb_dat_o       <= next_dat;
      analog_out_a_o <= next_ao_a;
      analog_out_b_o <= next_ao_b;
    end
  end

endmodule

`default_nettype wire

/* core/fhm_pkg.sv */
package fhm_pkg;

  // Clock and hour prescaler
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned HOUR_SECONDS    = 3600;
  localparam longint unsigned HOUR_CYCLES = longint'(CLK_HZ) * longint'(HOUR_SECONDS);

  // Hour counters: 0..65536 needs 17 bits; beyond 65536 power-on and run hours wrap to zero, hours between faults hold at 65536
  localparam int unsigned HOURS_W         = 17;
  localparam logic [16:0] HOURS_MAX       = 17'h10000;

  // Register byte offsets (one aligned word each)
  localparam logic [7:0] REG_FAULT_CUR    = 8'h00;
  localparam logic [7:0] REG_FAULT_PREV   = 8'h04;
  localparam logic [7:0] REG_FAULT_TWO    = 8'h08;
  localparam logic [7:0] REG_FAULT_THREE  = 8'h0c;
  localparam logic [7:0] REG_HRS_BETWEEN  = 8'h10;
  localparam logic [7:0] REG_CAP_FCMD     = 8'h14;
  localparam logic [7:0] REG_CAP_FOUT     = 8'h18;
  localparam logic [7:0] REG_CAP_CURR     = 8'h1c;
  localparam logic [7:0] REG_CAP_VOLT     = 8'h20;
  localparam logic [7:0] REG_CAP_BUS      = 8'h24;
  localparam logic [7:0] REG_CAP_PINS     = 8'h28;
  localparam logic [7:0] REG_PWR_HRS      = 8'h2c;
  localparam logic [7:0] REG_RUN_HRS      = 8'h30;
  localparam logic [7:0] REG_FW_VER       = 8'h34;
  localparam logic [7:0] REG_MOTOR_SPEED  = 8'h38;
  localparam logic [7:0] REG_AO_CTRL      = 8'h3c;
  localparam logic [7:0] REG_AO_VALUES    = 8'h40;
  localparam logic [7:0] REG_LOOP_MON     = 8'h44;
  localparam logic [7:0] REG_IRQ_STATUS   = 8'h48;
  localparam logic [7:0] REG_IRQ_MASK     = 8'h4c;
  localparam logic [7:0] REG_LIVE_PINS    = 8'h50;

  // Field positions
  localparam int unsigned CAP_IN_POS      = 0;
  localparam int unsigned CAP_OUT_POS     = 8;
  localparam int unsigned AO_A_SRC_POS    = 0;
  localparam int unsigned AO_B_SRC_POS    = 8;
  localparam int unsigned AO_A_GAIN_POS   = 16;
  localparam int unsigned AO_B_GAIN_POS   = 24;
  localparam int unsigned AO_B_VAL_POS    = 16;
  localparam int unsigned IRQ_FAULT_BIT   = 0;
  localparam int unsigned IRQ_CLEAR_BIT   = 1;
  localparam int unsigned IRQ_HOUR_BIT    = 2;

  // Reset values
  localparam logic [7:0]  AO_SRC_RESET    = 8'h01;
  localparam logic [7:0]  AO_GAIN_RESET   = 8'h64;
  localparam logic [2:0]  IRQ_MASK_RESET  = 3'h0;

  // Analog output source selector codes
  localparam logic [7:0] SRC_FREQ_CMD     = 8'h01;
  localparam logic [7:0] SRC_OUT_FREQ     = 8'h02;
  localparam logic [7:0] SRC_OUT_CURR     = 8'h03;
  localparam logic [7:0] SRC_OUT_VOLT     = 8'h04;
  localparam logic [7:0] SRC_VOLT_IN      = 8'h05;
  localparam logic [7:0] SRC_CURR_IN      = 8'h06;
  localparam logic [7:0] SRC_AUX_IN       = 8'h07;
  localparam logic [7:0] SRC_SPD_FB       = 8'h08;
  localparam logic [7:0] SRC_SPD_COMP     = 8'h09;
  localparam logic [7:0] SRC_LOOP_IN      = 8'h0a;
  localparam logic [7:0] SRC_LOOP_OUT     = 8'h0b;

  // Output scaling: 1000 = 100.0 % = 10 V full scale; gain in percent
  localparam logic [15:0] FULL_SCALE      = 16'h03e8;
  localparam logic [7:0]  GAIN_UNITY      = 8'h64;

  // Firmware version (arbitrary value)
  localparam logic [15:0] FW_VERSION      = 16'h0001;

  // Drive operating values
  typedef struct packed {
    logic [15:0] freq_cmd;     // 0.01 Hz
    logic [15:0] out_freq;     // 0.01 Hz
    logic [15:0] out_current;  // 0.1 A
    logic [15:0] out_voltage;  // 0.1 V
    logic [15:0] bus_voltage;  // 0.1 V
    logic [7:0]  in_pins;      // 1 = closed
    logic [7:0]  out_pins;     // 1 = closed
  } fhm_drive_s;

  // Monitored analog quantities, 0.1 % units
  typedef struct packed {
    logic [15:0] voltage_input;
    logic [15:0] current_input;
    logic [15:0] aux_input;
    logic [15:0] speed_fb;
    logic [15:0] speed_comp;
    logic [15:0] loop_in;
    logic [15:0] loop_out;
    logic [15:0] loop_feedback;
    logic [15:0] loop_target;
  } fhm_analog_s;

endpackage

/* sim/fhm_monitor_checker.sv */
`timescale 1ns/1ps
`default_nettype none

module fhm_monitor_checker (
  input wire logic        clk_i,          // Clock
  input wire logic        rst_i,          // Reset
  input wire logic [31:0] wb_adr_i,       // Address
  input wire logic        wb_we_i,        // Write enable
  input wire logic        wb_cyc_i,       // Cycle
  input wire logic        wb_stb_i,       // Strobe
  input wire logic [31:0] wb_dat_o,       // Read data
  input wire logic        wb_ack_o,       // Acknowledge
  input wire logic        fault_i,        // Fault pulse
  input wire logic [7:0]  fault_code_i,   // Fault code
  input wire logic        fault_reset_i,  // Fault reset
  input wire logic        encoder_fb_i,   // Encoder mode
  input wire logic [15:0] motor_rpm_i,    // Motor speed
  input wire logic [15:0] analog_out_a_o, // Output A
  input wire logic [15:0] analog_out_b_o  // Output B
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_rd(logic [7:0] a);
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i[7:0] == a;
  endsequence
  sequence s_quiet;
    !fault_i && !fault_reset_i;
  endsequence

  AST_ACK_TAKE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data without ack");
  AST_FW_READ: assert property (
    s_rd(fhm_pkg::REG_FW_VER) |=> wb_dat_o == {16'h0, fhm_pkg::FW_VERSION})
    else $error("firmware version wrong");
  AST_SPEED_OFF: assert property (
    s_rd(fhm_pkg::REG_MOTOR_SPEED) ##0 !encoder_fb_i |=> wb_dat_o == 32'h0)
    else $error("speed shown without encoder");
  AST_SPEED_ON: assert property (
    s_rd(fhm_pkg::REG_MOTOR_SPEED) ##0 encoder_fb_i |=> wb_dat_o[15:0] == $past(motor_rpm_i))
    else $error("speed value wrong");
  AST_SLOT_NEW: assert property (fault_i && !fault_reset_i ##1 s_quiet
    ##1 s_rd(fhm_pkg::REG_FAULT_CUR) ##0 s_quiet |=> wb_dat_o[7:0] == $past(fault_code_i, 3))
    else $error("current fault slot wrong");
  AST_SLOT_CLR: assert property (fault_reset_i ##1 s_quiet
    ##1 s_rd(fhm_pkg::REG_FAULT_CUR) ##0 s_quiet |=> wb_dat_o == 32'h0)
    else $error("fault slot not cleared");
  AST_AO_CLIP: assert property (analog_out_a_o <= fhm_pkg::FULL_SCALE
    && analog_out_b_o <= fhm_pkg::FULL_SCALE) else $error("analog output above full scale");
  AST_HRS_RANGE: assert property (
    s_rd(fhm_pkg::REG_HRS_BETWEEN) |=> wb_dat_o <= {15'h0, fhm_pkg::HOURS_MAX})
    else $error("hours between faults out of range");
endmodule

bind fhm_monitor fhm_monitor_checker chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .fault_i(fault_i), .fault_code_i(fault_code_i), .fault_reset_i(fault_reset_i),
  .encoder_fb_i(encoder_fb_i), .motor_rpm_i(motor_rpm_i),
  .analog_out_a_o(analog_out_a_o), .analog_out_b_o(analog_out_b_o));

`default_nettype wire

/* sim/fhm_monitor_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if (32'(a) !== 32'(e)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, 32'(a), 32'(e)); end end

module fhm_monitor_test;
  logic                clk_i = 1'b0;
  logic                rst_i = 1'b1;
  logic [31:0]         adr = '0, dat = '0, dat_o, q;
  logic [3:0]          sel = '0;
  logic                we = 0, cyc = 0, stb = 0, ack, irq;
  logic                fault = 0, frst = 0, run = 0, loop_en = 0, enc = 0;
  logic [7:0]          code = '0, c;
  logic [15:0]         rpm = 16'h0abc, lv = '0, s, ao_a, ao_b;
  fhm_pkg::fhm_drive_s  drive;
  fhm_pkg::fhm_analog_s analog;
  int                  num_errors = 0, n_checks = 0, cnt = 0, tk, t0, t1, p0, r0;

  fhm_plant plant (.level_i(lv), .drive_o(drive), .analog_o(analog));
  fhm_monitor #(.HOUR_CYCLES(1)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .irq_o(irq), .fault_i(fault), .fault_code_i(code), .fault_reset_i(frst),
    .run_i(run), .loop_enable_i(loop_en), .encoder_fb_i(enc), .motor_rpm_i(rpm),
    .drive_i(drive), .analog_i(analog), .analog_out_a_o(ao_a), .analog_out_b_o(ao_b));

  always #12.5 clk_i = ~clk_i;

  task test_done;
    if (num_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cnt <= cnt + 1;
    if (cnt == 80000) begin
      num_errors++;
      test_done;
    end
  end

  // Classic cycle: hold everything until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] m);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {24'h0, a};
    dat <= d;
    sel <= m;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = dat_o;
    tk = cnt;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask
  task automatic fault_ev(input logic [7:0] k, input logic [15:0] l);
    @(posedge clk_i);
    fault <= 1'b1;
    code <= k;
    lv <= l;
    @(posedge clk_i);
    fault <= 1'b0;
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(fhm_pkg::REG_AO_CTRL);
    `CHK(q, {fhm_pkg::AO_GAIN_RESET, fhm_pkg::AO_GAIN_RESET, 16'h0101})
    rd(fhm_pkg::REG_IRQ_MASK);
    `CHK(q, 0)
    wr(fhm_pkg::REG_FW_VER, 32'hffff);
    rd(fhm_pkg::REG_FW_VER);
    `CHK(q, fhm_pkg::FW_VERSION)
    rd(8'h7c);
    `CHK(q, 0)
    wr(fhm_pkg::REG_IRQ_MASK, 32'h1);
    for (int i = 1; i <= 5; i++) fault_ev(8'h10 + 8'(i), 16'h0100 * 16'(i));
    for (int k = 0; k < 4; k++) begin
      rd(fhm_pkg::REG_FAULT_CUR + 8'(4 * k));
      `CHK(q, 8'h15 - 8'(k))
    end
    for (int k = 0; k < 5; k++) begin
      rd(fhm_pkg::REG_CAP_FCMD + 8'(4 * k));
      `CHK(q, 16'h0500 + 16'(k))
    end
    rd(fhm_pkg::REG_CAP_PINS);
    `CHK(q, 32'h5aff)
    rd(fhm_pkg::REG_LIVE_PINS);
    `CHK(q, 32'h5aff)
    rd(fhm_pkg::REG_LOOP_MON);
    `CHK(q, 32'h05060505)
    `CHK(irq, 1'b1)
    wr(fhm_pkg::REG_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge clk_i);
    `CHK(irq, 1'b0)
    wr(fhm_pkg::REG_IRQ_MASK, 32'h0);
    fault_ev(8'h77, 16'h0200);
    repeat (2) @(posedge clk_i);
    `CHK(irq, 1'b0)
    rd(fhm_pkg::REG_IRQ_STATUS);
    `CHK(q[0], 1'b1)
    wr(fhm_pkg::REG_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk_i);
    `CHK(irq, 1'b1)
    rd(fhm_pkg::REG_MOTOR_SPEED);
    `CHK(q, 0)
    enc <= 1'b1;
    rd(fhm_pkg::REG_MOTOR_SPEED);
    `CHK(q, 16'h0abc)
    for (int i = 0; i < 6; i++) begin
      c = 8'h05 + 8'(i % 3);
      loop_en <= (i > 2);
      s = (i > 2) ? 16'h0200 + ((i == 5) ? 16'h8 : 16'h7) : 16'h0200 + 16'(i);
      wr(fhm_pkg::REG_AO_CTRL, {8'h32, 8'h64, c, c});
      repeat (3) @(posedge clk_i);
      `CHK(ao_a, s)
      `CHK(ao_b, s / 16'h2)
    end
    loop_en <= 1'b0;
    wr(fhm_pkg::REG_AO_CTRL, 32'hc8c80505);
    repeat (3) @(posedge clk_i);
    rd(fhm_pkg::REG_AO_VALUES);
    `CHK(q, {fhm_pkg::FULL_SCALE, fhm_pkg::FULL_SCALE})
    bus(1'b1, fhm_pkg::REG_AO_CTRL, 32'hffffff08, 4'h1);
    rd(fhm_pkg::REG_AO_CTRL);
    `CHK(q, 32'hc8c80508)
    rd(fhm_pkg::REG_RUN_HRS);
    r0 = q;
    rd(fhm_pkg::REG_RUN_HRS);
    `CHK(q, r0)
    run <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd(fhm_pkg::REG_PWR_HRS);
    p0 = q;
    t0 = tk;
    rd(fhm_pkg::REG_RUN_HRS);
    r0 = q;
    t1 = tk;
    repeat (65540) @(posedge clk_i);
    rd(fhm_pkg::REG_PWR_HRS);
    `CHK(q, (p0 + tk - t0) % 65537)
    rd(fhm_pkg::REG_RUN_HRS);
    `CHK(q, (r0 + tk - t1) % 65537)
    rd(fhm_pkg::REG_HRS_BETWEEN);
    `CHK(q, fhm_pkg::HOURS_MAX)
    @(posedge clk_i);
    frst <= 1'b1;
    t0 = cnt;
    @(posedge clk_i);
    frst <= 1'b0;
    rd(fhm_pkg::REG_FAULT_CUR);
    `CHK(q, 0)
    rd(fhm_pkg::REG_FAULT_THREE);
    `CHK(q, 0)
    rd(fhm_pkg::REG_CAP_FCMD);
    `CHK(q, 0)
    rd(fhm_pkg::REG_LOOP_MON);
    `CHK(q, 0)
    rd(fhm_pkg::REG_HRS_BETWEEN);
    // Zeroed at the reset edge, then one tick per cycle up to the taking edge
    `CHK(q, tk - t0 - 3)
    rd(fhm_pkg::REG_IRQ_STATUS);
    `CHK(q, 32'h7)
    test_done;
  end
endmodule

`default_nettype wire

/* sim/fhm_plant.sv */
`timescale 1ns/1ps
`default_nettype none

// Drive and analog values derived from one level, each field distinct
module fhm_plant (
  input  wire logic [15:0]   level_i,  // Operating level
  output fhm_pkg::fhm_drive_s  drive_o,  // Drive values
  output fhm_pkg::fhm_analog_s analog_o  // Analog monitors
);
  assign drive_o = {level_i, level_i + 16'h1, level_i + 16'h2, level_i + 16'h3,
                    level_i + 16'h4, ~level_i[7:0], level_i[7:0] ^ 8'h5a};
  assign analog_o = {level_i, level_i + 16'h1, level_i + 16'h2, level_i + 16'h3,
                     level_i + 16'h4, level_i + 16'h5, level_i + 16'h6,
                     level_i + 16'h7, level_i + 16'h8};
endmodule

`default_nettype wire
